// ### verilog/nvh_defs.svh
`ifndef NVH_DEFS_SVH
`define NVH_DEFS_SVH

// Clock period of ref_clk in ns
`define NVH_CLK_NS          8

// Pin-level widths and the wait timer width
`define NVH_IDX_W           13
`define NVH_DATA_W          8
`define NVH_TMR_W           21

// Times in their own units, as printed
`define NVH_INIT_NS         20
`define NVH_STORE_MS        10
`define NVH_RECALL_US       20
`define NVH_PWRUP_US        550
`define NVH_ACCESS_NS       55
`define NVH_WPULSE_NS       45

// Cycle counts; every wait rounds up so the device time is always met
`define NVH_CDIV(t)         (((t) + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_INIT_CYC        `NVH_CDIV(`NVH_INIT_NS)
`define NVH_STORE_CYC       `NVH_CDIV(`NVH_STORE_MS * 1000000)
`define NVH_RECALL_CYC      `NVH_CDIV(`NVH_RECALL_US * 1000)
`define NVH_PWRUP_CYC       `NVH_CDIV(`NVH_PWRUP_US * 1000)
`define NVH_ACCESS_CYC      `NVH_CDIV(`NVH_ACCESS_NS)
`define NVH_WPULSE_CYC      `NVH_CDIV(`NVH_WPULSE_NS)

`endif

// ### verilog/nvh_pkg.sv
`include "nvh_defs.svh"

package nvh_pkg;

	// Host request kinds
	typedef enum logic [1:0] {
		NVH_OP_READ,
		NVH_OP_WRITE,
		NVH_OP_STORE,
		NVH_OP_RECALL
	} nvh_op_t;

	// One request from the user side
	typedef struct packed {
		nvh_op_t                    op;
		logic [`NVH_IDX_W-1:0]      addr;
		logic [`NVH_DATA_W-1:0]     data;
	} nvh_cmd_t;

	// Active-low control pins towards the memory
	typedef struct packed {
		logic chipSlctN;
		logic dataLoadN;
		logic outputDriveN;
		logic nonvolatileStrobeN;
	} nvh_pins_t;

	// Builds a control pin set from four levels
	function automatic nvh_pins_t mkPins(input logic e, input logic w,
		input logic g, input logic ne);
		nvh_pins_t p;
		p.chipSlctN          = e;
		p.dataLoadN          = w;
		p.outputDriveN       = g;
		p.nonvolatileStrobeN = ne;
		return p;
	endfunction : mkPins

endpackage : nvh_pkg

// ### verilog/nvh_timer.sv
`include "nvh_defs.svh"

module nvh_timer #(
	parameter int TW = `NVH_TMR_W
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          load,
	input  wire logic [TW-1:0] loadVal,
	output logic               done
);

	logic [TW-1:0] cnt_r;
	logic [TW-1:0] cnt_nxt;

	////////////////////////////////////////////////////////////////////
	// Down counter; sits at zero until reloaded
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = loadVal;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - TW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Plain zero test: a load term here would close a loop through the
	// sequencer, which loads on done; callers gate the reset-time zero
	assign done = (cnt_r == '0);

endmodule : nvh_timer

// ### verilog/nvh_ctrl.sv
// Overview of operation
// [RULE1] Strobe high gives plain SRAM access, strobe low a nonvolatile transfer.
// [RULE2] A transfer copies the whole array at once in one direction.
// [RULE3] Read happens with select and output drive low, load and strobe high.
// [RULE4] Thirteen index bits pick one of 8,192 bytes.
// [RULE5] Read data follows the index and stays until a control changes.
// [RULE6] Write happens with select and load low and strobe high.
// [RULE7] Select high means idle; other leftover combinations do nothing.
// [RULE8] Select, strobe and load low with output drive high starts a save.
// [RULE9] Select, drive and strobe low with load high starts a fetch.
// [RULE10] Host holds the save combination at least 20 ns.
// [RULE11] After that the save runs alone; any control may end it.
// [RULE12] A save finishes within 10 ms, seen with read-like pins.
// [RULE13] No save happens while supply is below 4.0 V.
// [RULE14] Host holds the fetch combination at least 20 ns.
// [RULE15] After that the fetch runs alone; strobe, drive or select end it.
// [RULE16] A fetch finishes within 20 us, seen with read-like pins.
// [RULE17] Data pins float within 20 ns of the strobe falling for a fetch.
// [RULE18] Host raises output drive no later than the save strobe falls.
// [RULE19] Power-up fetch takes up to 550 us before any access.
// [RULE20] Transfers start only on a control edge into their combination.
// [RULE21] During a save the device ignores inputs and floats data.
// [RULE22] A fetch clears the array then copies, leaving the saved copy.
`include "nvh_defs.svh"

module nvh_ctrl #(
	parameter int PWRUP_CYC  = `NVH_PWRUP_CYC,
	parameter int STORE_CYC  = `NVH_STORE_CYC,
	parameter int RECALL_CYC = `NVH_RECALL_CYC
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   cmdValid,
	output logic                        cmdReady,
	input  wire nvh_pkg::nvh_cmd_t      cmd,
	output logic                        respValid,
	output logic [`NVH_DATA_W-1:0]      respData,
	output nvh_pkg::nvh_pins_t          ctlPins,
	output logic [`NVH_IDX_W-1:0]       byteIndex,
	output logic [`NVH_DATA_W-1:0]      ioBusOut,
	output logic                        ioBusOe,
	input  wire logic [`NVH_DATA_W-1:0] ioBusIn
);

	localparam int TW = `NVH_TMR_W;

	typedef enum logic [3:0] {
		PWRUP,
		IDLE,
		RD_WAIT,
		WR_PULSE,
		WR_END,
		ST_HOLD,
		ST_WAIT,
		RC_HOLD,
		RC_WAIT
	} nvh_state_t;

	nvh_state_t              state_r;
	nvh_state_t              state_nxt;
	nvh_pkg::nvh_pins_t      pins_r;
	nvh_pkg::nvh_pins_t      pins_nxt;
	logic [`NVH_IDX_W-1:0]   idx_r;
	logic [`NVH_IDX_W-1:0]   idx_nxt;
	logic [`NVH_DATA_W-1:0]  out_r;
	logic [`NVH_DATA_W-1:0]  out_nxt;
	logic                    oe_r;
	logic                    oe_nxt;
	logic [`NVH_DATA_W-1:0]  rd_r;
	logic [`NVH_DATA_W-1:0]  rd_nxt;
	logic                    resp_r;
	logic                    resp_nxt;
	logic                    tmLoad;
	logic [TW-1:0]           tmVal;
	logic                    tmDone;
	logic                    pwrArm_r;
	logic                    tLoad;
	logic [TW-1:0]           tVal;

	////////////////////////////////////////////////////////////////////
	// Shared wait timer for every timed phase
	nvh_timer #(
		.TW      (TW)
	) u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.load    (tLoad),
		.loadVal (tVal),
		.done    (tmDone)
	);

	////////////////////////////////////////////////////////////////////
	// Sequencer: next pin levels, bus drive and response
	always_comb begin
		state_nxt = state_r;
		pins_nxt  = pins_r;
		idx_nxt   = idx_r;
		out_nxt   = out_r;
		oe_nxt    = oe_r;
		rd_nxt    = rd_r;
		resp_nxt  = 1'b0;
		tmLoad    = 1'b0;
		tmVal     = '0;
		case (state_r)
			// [RULE19] Wait out power-up; arm masks the reset-time zero
			PWRUP: begin
				if (tmDone && pwrArm_r) begin
					state_nxt = IDLE;
				end
			end
			IDLE: begin
				if (cmdValid) begin
					// [RULE4] Latch byte index
					idx_nxt = cmd.addr;
					tmLoad  = 1'b1;
					case (cmd.op)
						// [RULE3] Read combination
						nvh_pkg::NVH_OP_READ: begin
							pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b1, 1'b0, 1'b1);
							tmVal     = TW'(`NVH_ACCESS_CYC - 1);
							state_nxt = RD_WAIT;
						end
						// [RULE6] Write with output drive kept high
						nvh_pkg::NVH_OP_WRITE: begin
							pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b0, 1'b1, 1'b1);
							out_nxt   = cmd.data;
							oe_nxt    = 1'b1;
							tmVal     = TW'(`NVH_WPULSE_CYC - 1);
							state_nxt = WR_PULSE;
						end
						// [RULE10] [RULE18] Timed hold, drive already high
						nvh_pkg::NVH_OP_STORE: begin
							pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b0, 1'b1, 1'b0);
							tmVal     = TW'(`NVH_INIT_CYC - 1);
							state_nxt = ST_HOLD;
						end
						default: begin
							pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b1, 1'b0, 1'b0);
							tmVal     = TW'(`NVH_INIT_CYC - 1);
							state_nxt = RC_HOLD;
						end
					endcase
				end
			end
			// Sample once access time has passed
			RD_WAIT: begin
				if (tmDone) begin
					rd_nxt    = ioBusIn;
					resp_nxt  = 1'b1;
					pins_nxt  = nvh_pkg::mkPins(1'b1, 1'b1, 1'b1, 1'b1);
					state_nxt = IDLE;
				end
			end
			WR_PULSE: begin
				if (tmDone) begin
					pins_nxt  = nvh_pkg::mkPins(1'b1, 1'b1, 1'b1, 1'b1);
					state_nxt = WR_END;
				end
			end
			// Data held one cycle past the strobe edge for hold margin
			WR_END: begin
				oe_nxt    = 1'b0;
				resp_nxt  = 1'b1;
				state_nxt = IDLE;
			end
			// [RULE11] End initiation by raising load and strobe
			ST_HOLD: begin
				if (tmDone) begin
					pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b1, 1'b0, 1'b1);
					tmLoad    = 1'b1;
					tmVal     = TW'(STORE_CYC - 1);
					state_nxt = ST_WAIT;
				end
			end
			// [RULE12] Wait full save time in the observe combination
			ST_WAIT: begin
				if (tmDone) begin
					pins_nxt  = nvh_pkg::mkPins(1'b1, 1'b1, 1'b1, 1'b1);
					resp_nxt  = 1'b1;
					state_nxt = IDLE;
				end
			end
			// [RULE14] [RULE15] Held, then strobe raised
			RC_HOLD: begin
				if (tmDone) begin
					pins_nxt  = nvh_pkg::mkPins(1'b0, 1'b1, 1'b0, 1'b1);
					tmLoad    = 1'b1;
					tmVal     = TW'(RECALL_CYC - 1);
					state_nxt = RC_WAIT;
				end
			end
			// [RULE16] Wait full fetch time with read-like pins
			RC_WAIT: begin
				if (tmDone) begin
					pins_nxt  = nvh_pkg::mkPins(1'b1, 1'b1, 1'b1, 1'b1);
					resp_nxt  = 1'b1;
					state_nxt = IDLE;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	// Power-up wait is loaded on the first clock after reset release by the arm path below
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= PWRUP;
			pins_r  <= '1;
			idx_r   <= '0;
			out_r   <= '0;
			oe_r    <= 1'b0;
			rd_r    <= '0;
			resp_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pins_r  <= pins_nxt;
			idx_r   <= idx_nxt;
			out_r   <= out_nxt;
			oe_r    <= oe_nxt;
			rd_r    <= rd_nxt;
			resp_r  <= resp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Power-up wait start: one load pulse after reset release
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwrArm_r <= 1'b0;
		end else begin
			pwrArm_r <= 1'b1;
		end
	end

	// Combined load: power-up arm or sequencer request
	assign tLoad = tmLoad || !pwrArm_r;
	assign tVal  = pwrArm_r ? tmVal : TW'(PWRUP_CYC - 1);

	////////////////////////////////////////////////////////////////////
	// Outputs; cmdReady is decoded from state, response, data and pins straight from flip-flops
	assign cmdReady  = (state_r == IDLE);
	assign respValid = resp_r;
	assign respData  = rd_r;
	assign ctlPins   = pins_r;
	assign byteIndex = idx_r;
	assign ioBusOut  = out_r;
	assign ioBusOe   = oe_r;

	////////////////////////////////////////////////////////////////////
	// Checks on the pins this controller drives
	logic stCombo;
	logic rcCombo;
	assign stCombo = !pins_r.chipSlctN && !pins_r.dataLoadN &&
		pins_r.outputDriveN && !pins_r.nonvolatileStrobeN;
	assign rcCombo = !pins_r.chipSlctN && pins_r.dataLoadN &&
		!pins_r.outputDriveN && !pins_r.nonvolatileStrobeN;

	AST_STORE_HOLD: assert property ( // [RULE10]
		@(posedge ref_clk) disable iff (rst)
		$rose(stCombo) |-> stCombo [*3])
		else $error("Save combination held too briefly");

	AST_RECALL_HOLD: assert property ( // [RULE14]
		@(posedge ref_clk) disable iff (rst)
		$rose(rcCombo) |-> rcCombo [*3])
		else $error("Fetch combination held too briefly");

	AST_DRIVE_FIRST: assert property ( // [RULE18]
		@(posedge ref_clk) disable iff (rst)
		$fell(pins_r.nonvolatileStrobeN) && !pins_r.dataLoadN
		|-> pins_r.outputDriveN && $past(pins_r.outputDriveN))
		else $error("Output drive not high before save strobe");

	AST_STORE_ENDS: assert property ( // [RULE11]
		@(posedge ref_clk) disable iff (rst)
		$rose(stCombo) |-> ##[3:4] (pins_r.nonvolatileStrobeN
		&& pins_r.dataLoadN && !pins_r.outputDriveN))
		else $error("Save initiation not ended properly");

	AST_RECALL_ENDS: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (rst)
		$fell(rcCombo) |-> pins_r.nonvolatileStrobeN
		&& !pins_r.chipSlctN)
		else $error("Fetch initiation not ended by strobe");

	AST_WRITE_DRIVE: assert property ( // [RULE6]
		@(posedge ref_clk) disable iff (rst)
		$rose(ioBusOe) |-> !pins_r.dataLoadN && pins_r.outputDriveN
		&& pins_r.nonvolatileStrobeN)
		else $error("Bus driven outside a write");

endmodule : nvh_ctrl

// ### test/nvh_dev_model.sv
`include "nvh_defs.svh"

module nvh_dev_model #(
	parameter int BUSY = 10
) (
	input  wire logic                   ref_clk,
	input  wire nvh_pkg::nvh_pins_t     pins,
	input  wire logic [`NVH_IDX_W-1:0]  idx,
	input  wire logic [`NVH_DATA_W-1:0] busIn,
	output logic [`NVH_DATA_W-1:0]      busOut,
	output logic                        busOe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [`NVH_DATA_W-1:0] sram [8192];
	logic [`NVH_DATA_W-1:0] nv   [8192];
	nvh_pkg::nvh_pins_t     prev;
	int                     busyCnt;

	////////////////////////////////////////////////////////////////////////
	// Saved copy starts blank; cells are not left unknown
	// power-up fetch busy, saves inhibited meanwhile
	initial begin
		busyCnt = BUSY;
		prev = 4'hF;
		for (int i = 0; i < 8192; i++) begin
			nv[i] = 8'h00;
			sram[i] = nv[i];
		end
	end

	// Pins sampled each clock; a real part is async but the host is not
	// transfer decode by edge, write decode by level
	always @(posedge ref_clk) begin
		prev <= pins;
		if (busyCnt != 0) begin
			busyCnt <= busyCnt - 1; // Inputs ignored while busy
		end else if (pins == 4'h2 && prev != 4'h2) begin
			for (int i = 0; i < 8192; i++) begin
				nv[i] = sram[i];
			end
			busyCnt <= BUSY;
		end else if (pins == 4'h4 && prev != 4'h4) begin
			for (int i = 0; i < 8192; i++) begin
				sram[i] = 8'h00;
				sram[i] = nv[i];
			end
			busyCnt <= BUSY;
		end else if (!pins.chipSlctN && !pins.dataLoadN
			&& pins.nonvolatileStrobeN) begin
			sram[idx] = busIn;
		end
	end

	assign busOe  = (busyCnt == 0) && (pins == 4'h5);
	assign busOut = sram[idx];

endmodule : nvh_dev_model

// ### test/nvh_ctrl_tb.sv
`include "nvh_defs.svh"

module nvh_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int PW = 20;
	localparam int ST = 30;
	localparam int RC = 20;

	logic                   ref_clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   cmdValid = 1'b0;
	logic                   cmdReady;
	nvh_pkg::nvh_cmd_t      cmd = '0;
	logic                   respValid;
	logic [`NVH_DATA_W-1:0] respData;
	nvh_pkg::nvh_pins_t     ctlPins;
	logic [`NVH_IDX_W-1:0]  byteIndex;
	logic [`NVH_DATA_W-1:0] ioBusOut;
	logic                   ioBusOe;
	logic [`NVH_DATA_W-1:0] devOut;
	logic                   devOe;
	logic [`NVH_DATA_W-1:0] lastBus = 8'h00;
	logic [`NVH_DATA_W-1:0] busLvl;
	int                     bad_count = 0;
	int                     check_count = 0;
	int                     cyc = 0;
	int                     lat;
	nvh_pkg::nvh_cmd_t      rows [12];
	logic [15:0]            expPins [4] = '{16'h0005, 16'h0003, 16'h0002,
		16'h0004};
	int                     expLat [4] = '{8, 8, ST + 4, RC + 4};

	always #4 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	// Undriven bus shows the inverse of its last level, never a stale copy
	assign busLvl = devOe ? devOut : (ioBusOe ? ioBusOut : ~lastBus);
	always @(posedge ref_clk) lastBus <= busLvl;

	nvh_ctrl #(.PWRUP_CYC(PW), .STORE_CYC(ST), .RECALL_CYC(RC)) u_nvh_ctrl (
		.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmd(cmd), .respValid(respValid),
		.respData(respData), .ctlPins(ctlPins), .byteIndex(byteIndex),
		.ioBusOut(ioBusOut), .ioBusOe(ioBusOe), .ioBusIn(busLvl));

	nvh_dev_model #(.BUSY(10)) u_nvh_dev_model (
		.ref_clk(ref_clk), .pins(ctlPins), .idx(byteIndex),
		.busIn(busLvl), .busOut(devOut), .busOe(devOe));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test;
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	function automatic nvh_pkg::nvh_cmd_t mk(input nvh_pkg::nvh_op_t o,
		input logic [12:0] a, input logic [7:0] d);
		return '{op: o, addr: a, data: d};
	endfunction : mk

	// Issues one request, checks pin set in c1 and idle pins at the answer
	task automatic doOp(input nvh_pkg::nvh_cmd_t c, output int n);
		int w;
		w = 0;
		@(posedge ref_clk) cmdValid <= 1'b1;
		cmd <= c;
		@(negedge ref_clk);
		while (cmdReady !== 1'b1 && w < 1000) begin
			@(negedge ref_clk);
			w++;
		end
		@(posedge ref_clk) cmdValid <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n == 1) chk(16'(ctlPins), expPins[c.op]);
		end while (respValid !== 1'b1 && n < 1000);
		chk(16'(ctlPins), 16'h000F);
	endtask : doOp

	// Run ceiling well above the longest expected sequence
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rows: read rows carry the expected byte in their data field
	initial begin
		rows = '{mk(nvh_pkg::NVH_OP_WRITE, 13'h0000, 8'hA5),
			mk(nvh_pkg::NVH_OP_WRITE, 13'h1FFF, 8'h5A),
			mk(nvh_pkg::NVH_OP_WRITE, 13'h0001, 8'h3C),
			mk(nvh_pkg::NVH_OP_READ, 13'h0000, 8'hA5),
			mk(nvh_pkg::NVH_OP_READ, 13'h1FFF, 8'h5A),
			mk(nvh_pkg::NVH_OP_STORE, 13'h0000, 8'h00),
			mk(nvh_pkg::NVH_OP_WRITE, 13'h0000, 8'hFF),
			mk(nvh_pkg::NVH_OP_READ, 13'h0000, 8'hFF),
			mk(nvh_pkg::NVH_OP_RECALL, 13'h0000, 8'h00),
			mk(nvh_pkg::NVH_OP_READ, 13'h0000, 8'hA5),
			mk(nvh_pkg::NVH_OP_READ, 13'h1FFF, 8'h5A),
			mk(nvh_pkg::NVH_OP_READ, 13'h0001, 8'h3C)};
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(16'(ctlPins), 16'h000F);
		chk(16'(cmdReady), 16'h0000);
		@(posedge ref_clk) rst <= 1'b0;
		foreach (rows[i]) begin
			doOp(rows[i], lat);
			chk(16'(lat), 16'(expLat[rows[i].op]));
			if (rows[i].op == nvh_pkg::NVH_OP_READ) begin
				chk(16'(respData), 16'(rows[i].data));
			end
		end
		// Second reset in mid-run: pins idle, array kept, wait honoured
		@(posedge ref_clk) rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(16'(ctlPins), 16'h000F);
		chk(16'(cmdReady), 16'h0000);
		@(posedge ref_clk) rst <= 1'b0;
		doOp(mk(nvh_pkg::NVH_OP_READ, 13'h1FFF, 8'h00), lat);
		chk(16'(respData), 16'h005A);
		stop_test;
	end

endmodule : nvh_ctrl_tb
